// ==== ldfl_pkg.sv ====
package ldfl_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
	localparam int unsigned LAMP_INRUSH_US   = 10;
	localparam int unsigned LAMP_INRUSH_CYC  =
		(LAMP_INRUSH_US * (CLK_FREQ_HZ / 1_000_000) > 0) ?
		LAMP_INRUSH_US * (CLK_FREQ_HZ / 1_000_000) : 1;
	localparam int unsigned LAMP_CNT_W       = 8;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic        CMD_RESET        = 1'b1;
	localparam logic        FAULT_RESET      = 1'b0;
endpackage

// ==== ldfl_top.sv ====
// Behaviour
// - The injector output is the inverse of the injector command.
// - Shorted coil and open coil or wiring on the injector are fault events.
// - Injector overvoltage, overcurrent and overtemperature are faults too.
// - The injector fault line rests low and rises on any present fault.
// - A raised injector fault clears on a low-then-high command if gone.
// - The relay channel is an inverting twin with the same detection.
// - The relay fault line latches and clears exactly like the injector one.
// - The lamp channel is protected but offers no fault line.
// - Lamp overcurrent is tolerated for an inrush time before it trips.
// - The lamp output never enables a fault sense sink while off.
// - The ignition pre-driver has one input and a high and a low stage.
// - Ignition is non-inverting: high command drives the high stage.
// - The divided collector sense flags a short to battery on ignition.
`timescale 1ns/1ps
module ldfl_top
	import ldfl_pkg::*;
#(
	parameter int unsigned INRUSH_CYC = LAMP_INRUSH_CYC
) (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic injector_command_i,
	input  wire logic injector_short_i,
	input  wire logic injector_open_i,
	input  wire logic injector_protect_i,
	input  wire logic relay_command_i,
	input  wire logic relay_short_i,
	input  wire logic relay_open_i,
	input  wire logic relay_protect_i,
	input  wire logic lamp_command_i,
	input  wire logic lamp_overcurrent_i,
	input  wire logic lamp_protect_i,
	input  wire logic ignition_command_i,
	input  wire logic ignition_collector_sense_i,
	output logic      injector_output_o,
	output logic      injector_fault_o,
	output logic      relay_output_o,
	output logic      relay_fault_o,
	output logic      lamp_output_o,
	output logic      lamp_sense_sink_o,
	output logic      ignition_high_stage_o,
	output logic      ignition_low_stage_o,
	output logic      ignition_short_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                  inj_cmd;
		logic                  inj_out;
		logic                  inj_flt;
		logic                  rel_cmd;
		logic                  rel_out;
		logic                  rel_flt;
		logic                  lamp_out;
		logic                  lamp_trip;
		logic [LAMP_CNT_W-1:0] lamp_cnt;
		logic                  lamp_sink;
		logic                  ign_hi;
		logic                  ign_lo;
		logic                  ign_short;
	} ldfl_state_t;

	ldfl_state_t st;
	ldfl_state_t next_st;
	logic        inj_cond;
	logic        rel_cond;
	logic        inj_rise;
	logic        rel_rise;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		inj_cond = injector_short_i | injector_open_i | injector_protect_i;
		rel_cond = relay_short_i | relay_open_i | relay_protect_i;
		inj_rise = injector_command_i & ~st.inj_cmd;
		rel_rise = relay_command_i & ~st.rel_cmd;
		next_st.inj_cmd = injector_command_i;
		next_st.rel_cmd = relay_command_i;
		// Output pin active low: low value means the low-side switch is on
		next_st.inj_out = ~injector_command_i;
		next_st.rel_out = ~relay_command_i;
		// Set wins over clear so a fault during the retoggle is never lost
		if (inj_cond) begin
			next_st.inj_flt = 1'b1;
		end else if (inj_rise) begin
			next_st.inj_flt = 1'b0;
		end
		if (rel_cond) begin
			next_st.rel_flt = 1'b1;
		end else if (rel_rise) begin
			next_st.rel_flt = 1'b0;
		end
		// Lamp: count overcurrent, trip only after the inrush allowance
		// Counter width limits INRUSH_CYC to 2**LAMP_CNT_W cycles at most
		if (!lamp_overcurrent_i || !lamp_command_i) begin
			next_st.lamp_cnt = '0;
			if (!lamp_command_i) begin
				next_st.lamp_trip = 1'b0;
			end
		end else if (32'(st.lamp_cnt) + 32'd1 >= INRUSH_CYC) begin
			next_st.lamp_trip = 1'b1;
		end else begin
			next_st.lamp_cnt = st.lamp_cnt + 1'b1;
		end
		next_st.lamp_out = lamp_command_i & ~lamp_protect_i &
			~next_st.lamp_trip;
		// No sense sink at all: its leakage would make an LED glow while off
		next_st.lamp_sink = 1'b0;
		next_st.ign_hi = ignition_command_i;
		next_st.ign_lo = ~ignition_command_i;
		// Collector still high while the high stage drives means a short;
		// with the switch off a high collector is normal, so it is ignored
		next_st.ign_short = ignition_command_i &
			ignition_collector_sense_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '{inj_cmd: CMD_RESET, inj_out: 1'b0, inj_flt: FAULT_RESET,
				rel_cmd: CMD_RESET, rel_out: 1'b0, rel_flt: FAULT_RESET,
				lamp_out: 1'b0, lamp_trip: 1'b0, lamp_cnt: '0,
				lamp_sink: 1'b0,
				ign_hi: 1'b0, ign_lo: 1'b1, ign_short: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign injector_output_o     = st.inj_out;
	assign injector_fault_o      = st.inj_flt;
	assign relay_output_o        = st.rel_out;
	assign relay_fault_o         = st.rel_flt;
	assign lamp_output_o         = st.lamp_out;
	assign lamp_sense_sink_o     = st.lamp_sink;
	assign ignition_high_stage_o = st.ign_hi;
	assign ignition_low_stage_o  = st.ign_lo;
	assign ignition_short_o      = st.ign_short;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence inj_retoggle_s;
		!injector_command_i ##1 injector_command_i;
	endsequence

	sequence rel_retoggle_s;
		!relay_command_i ##1 relay_command_i;
	endsequence

	sequence lamp_start_s;
		!lamp_command_i ##1
		lamp_command_i && lamp_overcurrent_i && !lamp_protect_i;
	endsequence

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	chk_inj_invert: assert property (
		##1 injector_output_o == !$past(injector_command_i))
		else $error("injector output not inverted");
	chk_inj_raise: assert property (
		(injector_short_i | injector_open_i | injector_protect_i)
		|=> injector_fault_o)
		else $error("injector fault not raised");
	chk_inj_rest: assert property (
		!injector_fault_o && !inj_cond |=> !injector_fault_o)
		else $error("injector fault raised without cause");
	chk_inj_hold: assert property (
		injector_fault_o && !(injector_command_i && !$past(injector_command_i))
		|=> injector_fault_o)
		else $error("injector fault dropped without retoggle");
	chk_inj_clear: assert property (
		inj_retoggle_s ##0 !inj_cond |=> !injector_fault_o)
		else $error("injector fault not cleared by retoggle");
	chk_rel_raise: assert property (
		rel_cond |=> relay_fault_o)
		else $error("relay fault not raised");
	chk_rel_rest: assert property (
		!relay_fault_o && !rel_cond |=> !relay_fault_o)
		else $error("relay fault raised without cause");
	chk_rel_latch: assert property (
		relay_fault_o && !relay_command_i && !rel_cond |=> relay_fault_o)
		else $error("relay fault not latched");
	chk_rel_hold: assert property (
		relay_fault_o && !(relay_command_i && !$past(relay_command_i))
		|=> relay_fault_o)
		else $error("relay fault dropped without retoggle");
	chk_rel_clear: assert property (
		rel_retoggle_s ##0 !rel_cond |=> !relay_fault_o)
		else $error("relay fault not cleared by retoggle");
	chk_rel_invert: assert property (
		##1 relay_output_o == !$past(relay_command_i))
		else $error("relay output not inverted");
	chk_lamp_inrush: assert property (
		lamp_start_s |=> lamp_output_o)
		else $error("lamp tripped inside inrush window");
	chk_lamp_trip: assert property (
		st.lamp_trip && lamp_command_i |=> !lamp_output_o)
		else $error("tripped lamp switched back on");
	chk_lamp_off: assert property (
		!lamp_command_i || lamp_protect_i |=> !lamp_output_o)
		else $error("lamp on while off or protected");
	chk_ign_stages: assert property (
		##1 ignition_high_stage_o == $past(ignition_command_i) &&
		ignition_low_stage_o != ignition_high_stage_o)
		else $error("ignition stages wrong");
	chk_ign_short: assert property (
		##1 ignition_short_o == ($past(ignition_command_i) &&
		$past(ignition_collector_sense_i)))
		else $error("ignition short flag wrong");
endmodule

// ==== ldfl_mcu.sv ====
`timescale 1ns/1ps
module ldfl_mcu (
	input  wire logic [1:0] command_i,
	input  wire logic [1:0] fault_i,
	output logic      [1:0] short_o,
	output logic      [1:0] open_o
);
	// Class of a raised fault from the command level seen with it
	assign short_o = fault_i & command_i;
	assign open_o  = fault_i & ~command_i;
endmodule

// ==== ldfl_top_tb.sv ====
`timescale 1ns/1ps
module ldfl_top_tb;
	import ldfl_pkg::*;
	localparam int unsigned INR = 4;
	logic       clk, rst, lamp_cmd, lamp_oc, lamp_pr, ign_cmd, ign_sense;
	logic [1:0] cmd, out, fo, sh, op;
	logic [5:0] f;
	logic       lamp_out, sink, ig_h, ig_l, ig_s;
	int         n_mismatch, tests_run;
	ldfl_top #(.INRUSH_CYC(INR)) dut (.core_clk_i(clk), .rst_i(rst),
		.injector_command_i(cmd[0]), .injector_short_i(f[0]),
		.injector_open_i(f[1]), .injector_protect_i(f[2]),
		.relay_command_i(cmd[1]), .relay_short_i(f[3]),
		.relay_open_i(f[4]), .relay_protect_i(f[5]),
		.lamp_command_i(lamp_cmd), .lamp_overcurrent_i(lamp_oc),
		.lamp_protect_i(lamp_pr), .ignition_command_i(ign_cmd),
		.ignition_collector_sense_i(ign_sense),
		.injector_output_o(out[0]), .injector_fault_o(fo[0]),
		.relay_output_o(out[1]), .relay_fault_o(fo[1]),
		.lamp_output_o(lamp_out), .lamp_sense_sink_o(sink),
		.ignition_high_stage_o(ig_h), .ignition_low_stage_o(ig_l),
		.ignition_short_o(ig_s));
	ldfl_mcu mcu (.command_i(cmd), .fault_i(fo), .short_o(sh), .open_o(op));
	// ------------------------------------------------------------
	// Clock, helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Raise, hold, refused clear, then a clean low-high clear
	task fault_case(input int ch, input int k);
		f[3*ch+k] = 1'b1;
		step(2);
		chk(fo[ch], 1'b1);
		chk(sh[ch], 1'b1);
		f[3*ch+k] = 1'b0;
		step(2);
		chk(fo[ch], 1'b1);
		cmd[ch] = 1'b0;
		f[3*ch+k] = 1'b1;
		step(1);
		chk(op[ch], 1'b1);
		chk(out[ch], 1'b1);
		cmd[ch] = 1'b1;
		step(1);
		f[3*ch+k] = 1'b0;
		step(2);
		chk(fo[ch], 1'b1);
		cmd[ch] = 1'b0;
		step(1);
		cmd[ch] = 1'b1;
		step(2);
		chk(fo[ch], 1'b0);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		cmd = 2'b11;
		f = 6'h00;
		{lamp_cmd, lamp_oc, lamp_pr, ign_cmd, ign_sense} = 5'h00;
		n_mismatch = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		step(2);
		chk(out[0], 1'b0);
		chk(out[1], 1'b0);
		cmd = 2'b00;
		step(2);
		chk(out[0], 1'b1);
		chk(out[1], 1'b1);
		cmd = 2'b11;
		step(2);
		for (int ch = 0; ch < 2; ch++)
			for (int k = 0; k < 3; k++)
				fault_case(ch, k);
		// Reset in mid-run drops a latched fault and leaves no false edge
		f[0] = 1'b1;
		step(2);
		chk(fo[0], 1'b1);
		rst = 1'b1;
		f[0] = 1'b0;
		step(1);
		chk(fo[0], 1'b0);
		chk(ig_l, 1'b1);
		rst = 1'b0;
		step(2);
		chk(fo[0], 1'b0);
		chk(out[0], 1'b0);
		ign_cmd = 1'b1;
		step(2);
		chk(ig_h, 1'b1);
		chk(ig_l, 1'b0);
		chk(ig_s, 1'b0);
		ign_sense = 1'b1;
		step(2);
		chk(ig_s, 1'b1);
		ign_cmd = 1'b0;
		step(2);
		chk(ig_l, 1'b1);
		chk(ig_s, 1'b0);
		ign_sense = 1'b0;
		step(2);
		chk(ig_s, 1'b0);
		lamp_cmd = 1'b1;
		step(2);
		chk(sink, 1'b0);
		chk(lamp_out, 1'b1);
		lamp_oc = 1'b1;
		step(INR - 1);
		chk(lamp_out, 1'b1);
		step(1);
		chk(lamp_out, 1'b0);
		lamp_oc = 1'b0;
		step(2);
		chk(lamp_out, 1'b0);
		lamp_cmd = 1'b0;
		lamp_oc = 1'b1;
		step(2);
		chk(sink, 1'b0);
		chk(lamp_out, 1'b0);
		lamp_cmd = 1'b1;
		step(2);
		chk(lamp_out, 1'b1);
		lamp_oc = 1'b0;
		lamp_pr = 1'b1;
		step(2);
		chk(lamp_out, 1'b0);
		lamp_pr = 1'b0;
		for (int i = 0; i < 4; i++) begin
			lamp_cmd = ~lamp_cmd;
			step(2);
			chk(lamp_out, lamp_cmd);
		end
		stop_test;
	end
	// Run needs well under a thousand cycles
	initial begin
		#200000;
		n_mismatch++;
		stop_test;
	end
endmodule
